// ===== sim/pwmp_far_model.sv
// far side: sync wire with wired-OR source, pulse counters of the switches
`timescale 1ns/1ps
module pwmp_far_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   input wire logic ext_sync,
   input wire logic drive_a,
   input wire logic drive_b,
   output logic sync_in,
   output int cnt_a,
   output int cnt_b
);
   logic a_q;
   logic b_q;
   // wire pulled low when released
   assign sync_in = (!sync_oe_n && sync_out) || ext_sync;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         cnt_a <= 0;
         cnt_b <= 0;
      end else begin
         a_q <= drive_a;
         b_q <= drive_b;
         if (drive_a && !a_q) cnt_a <= cnt_a + 1;
         if (drive_b && !b_q) cnt_b <= cnt_b + 1;
      end
   end
endmodule

// ===== sim/pwmp_pulse_logic_props.sv
// checker of the pulse processing logic outputs
`timescale 1ns/1ps
module pwmp_pulse_logic_props (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic drive_a,
   input wire logic drive_b,
   input wire logic lockout,
   input wire logic ss_reset_n,
   input wire logic toggle_sel,
   input wire logic cycle_start,
   input wire logic sync_out,
   input wire logic sync_oe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic [1:0] last_q;
   logic [1:0] last_d;
   logic prev_q;
   logic start_q;
   logic done_q;
   logic done_d;
   // done marks a pulse that ended inside the charge phase of this cycle
   always_comb begin
      last_d = last_q;
      if (drive_a) last_d = 2'h1;
      if (drive_b) last_d = 2'h2;
      done_d = done_q | (prev_q & !(drive_a || drive_b));
      if (cycle_start || start_q) done_d = 1'b0;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         last_q <= 2'h0;
         prev_q <= 1'b0;
         start_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         last_q <= last_d;
         prev_q <= drive_a || drive_b;
         start_q <= cycle_start;
         done_q <= done_d;
      end
   end
   both_on_a: assert property (!(drive_a && drive_b)) else $error("both drivers on");
   lock_drv_a: assert property (lockout ##1 lockout |-> !drive_a && !drive_b)
      else $error("drive during lockout");
   lock_ss_a: assert property (lockout ##1 lockout |-> !ss_reset_n) else $error("soft start free");
   one_pulse_a: assert property (done_q |-> !(drive_a || drive_b)) else $error("second pulse in cycle");
   cycle_gap_a: assert property (cycle_start |=> ##[0:600] cycle_start) else $error("no cycle start");
   same_drv_a: assert property ($rose(drive_a) |-> last_q != 2'h1) else $error("double pulse on a");
   same_drv_b_a: assert property ($rose(drive_b) |-> last_q != 2'h2) else $error("double pulse on b");
   route_a: assert property ($rose(drive_a || drive_b) |-> drive_b == toggle_sel)
      else $error("pulse on wrong driver");
   tog_time_a: assert property ($changed(toggle_sel) |-> cycle_start || $past(cycle_start))
      else $error("toggle off cycle start");
   sync_drv_a: assert property (cycle_start |-> !sync_oe_n && sync_out ##2 sync_oe_n && !sync_out)
      else $error("sync pulse shape");
   dead_a: assert property (cycle_start |=> ##1 (!drive_a && !drive_b)[*8]) else $error("drive in dead");
endmodule
bind pwmp_pulse_logic pwmp_pulse_logic_props u_props (.clk, .reset_n, .drive_a, .drive_b, .lockout,
   .ss_reset_n, .toggle_sel, .cycle_start, .sync_out, .sync_oe_n);

// ===== sim/tb.sv
// testbench of the pulse processing logic
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic pwm_cmp = 1'b0;
   logic cur_ok = 1'b1;
   logic shutdown_n = 1'b1;
   logic ref_ok = 1'b0;
   logic ss_reset_ext_n = 1'b1;
   logic ext_sync = 1'b0;
   logic [pwmp_pkg::DEAD_EXT_W-1:0] dead_ext = 8'h00;
   logic sync_in, sync_out, sync_oe_n, drive_a, drive_b, ss_reset_n, lockout, toggle_sel, cycle_start;
   int cnt_a, cnt_b, n, a0, b0;
   int failures = 0;
   int checks = 0;
   logic t0;
   pwmp_pulse_logic u_dut (.clk, .reset_n, .pwm_cmp, .cur_ok, .shutdown_n, .ref_ok, .ss_reset_ext_n,
      .dead_ext, .sync_in, .sync_out, .sync_oe_n, .drive_a, .drive_b, .ss_reset_n, .lockout,
      .toggle_sel, .cycle_start);
   pwmp_far_model u_far (.clk, .reset_n, .sync_out, .sync_oe_n, .ext_sync, .drive_a, .drive_b,
      .sync_in, .cnt_a, .cnt_b);
   initial forever #50 clk = ~clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task gap; // negedges up to the next cycle start
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cycle_start !== 1'b1 && n < 700);
      if (n >= 700) begin
         failures++;
         close_out;
      end
   endtask
   task t_lock;
      @(posedge clk);
      pwm_cmp <= 1'b1;
      repeat (2) gap;
      chk(cnt_a + cnt_b, 0);
      chk({lockout, ss_reset_n}, 2'h2);
      @(posedge clk);
      ref_ok <= 1'b1;
      repeat (8) @(negedge clk);
      chk({lockout, ss_reset_n}, 2'h1);
      @(posedge clk);
      ss_reset_ext_n <= 1'b0;
      repeat (8) @(negedge clk);
      chk(ss_reset_n, 1'b0);
      @(posedge clk);
      ss_reset_ext_n <= 1'b1;
      $display("lock done");
   endtask
   task t_alt;
      gap;
      a0 = cnt_a;
      b0 = cnt_b;
      repeat (4) gap;
      chk(cnt_a - a0, 2);
      chk(cnt_b - b0, 2);
      $display("alternate done");
   endtask
   task t_kill(input int sel);
      gap;
      a0 = cnt_a + cnt_b;
      repeat (20) @(posedge clk);
      if (sel == 0) shutdown_n <= 1'b0;
      else if (sel == 1) cur_ok <= 1'b0;
      else pwm_cmp <= 1'b0;
      repeat (6) @(negedge clk);
      chk(drive_a | drive_b, 1'b0);
      @(posedge clk);
      shutdown_n <= 1'b1;
      cur_ok <= 1'b1;
      pwm_cmp <= 1'b1;
      gap;
      chk(cnt_a + cnt_b - a0, 1);
      $display("early end %0d done", sel);
   endtask
   task t_none;
      gap;
      @(posedge clk);
      shutdown_n <= 1'b0;
      repeat (3) @(negedge clk);
      t0 = toggle_sel;
      repeat (2) gap;
      repeat (3) @(negedge clk);
      chk(toggle_sel, t0);
      @(posedge clk);
      shutdown_n <= 1'b1;
      a0 = cnt_a;
      b0 = cnt_b;
      gap;
      chk(t0 ? cnt_b - b0 : cnt_a - a0, 1);
      $display("no pulse done");
   endtask
   task t_sync;
      gap;
      gap;
      chk(n, pwmp_pkg::OSC_CYC);
      repeat (100) @(posedge clk);
      ext_sync <= 1'b1;
      repeat (3) @(posedge clk);
      ext_sync <= 1'b0;
      gap;
      chk(n < 10, 1'b1);
      @(posedge clk);
      dead_ext <= 8'h05;
      gap;
      gap;
      chk(n, pwmp_pkg::OSC_CYC + 5);
      @(posedge clk);
      dead_ext <= 8'h00;
      $display("sync done");
   endtask
   task t_rst;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(negedge clk);
      chk({drive_a, drive_b, sync_out, sync_oe_n, lockout, ss_reset_n, toggle_sel, cycle_start}, 8'h18);
      @(posedge clk);
      reset_n <= 1'b1;
      gap;
      gap;
      chk(cnt_a, 1);
      chk(cnt_b, 0);
      $display("reset done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_lock;
      t_alt;
      for (int i = 0; i < 3; i++) t_kill(i);
      t_none;
      t_sync;
      t_rst;
      close_out;
   end
endmodule

// ===== verilog/pwmp_in_sync.sv
// three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/1ps
module pwmp_in_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   logic [W-1:0] out_d;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_comb begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         out_q <= RST;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync = out_q;
endmodule

// ===== verilog/pwmp_osc.sv
// cycle timer: charge and dead phases, sync pulse out, external sync in
`timescale 1ns/1ps
module pwmp_osc (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sync_line,
   input wire logic [pwmp_pkg::DEAD_EXT_W-1:0] dead_ext,
   output pwmp_pkg::pwmp_osc_s osc
);
   pwmp_pkg::pwmp_osc_e state_q;
   pwmp_pkg::pwmp_osc_e state_d;
   logic [pwmp_pkg::CNT_W-1:0] cnt_q;
   logic [pwmp_pkg::CNT_W-1:0] cnt_d;
   logic start_q;
   logic start_d;
   logic drive_q;
   logic drive_d;
   logic line_q;
   logic ext_rise;
   logic [pwmp_pkg::CNT_W-1:0] dead_last;

   // own drive is seen back during discharge only, so ext edges count in charge
   assign ext_rise = sync_line & ~line_q;
   assign dead_last = pwmp_pkg::DEAD_BASE + {{(pwmp_pkg::CNT_W-pwmp_pkg::DEAD_EXT_W){1'b0}}, dead_ext}
                      - pwmp_pkg::CNT_W'(1);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + pwmp_pkg::CNT_W'(1);
      start_d = 1'b0;
      drive_d = 1'b0;
      case (state_q)
         pwmp_pkg::PWMP_OSC_CHARGE: begin
            if (cnt_q == pwmp_pkg::CHARGE_LAST || ext_rise) begin
               state_d = pwmp_pkg::PWMP_OSC_DISCHARGE;
               cnt_d = '0;
               start_d = 1'b1;
               drive_d = 1'b1;
            end
         end
         pwmp_pkg::PWMP_OSC_DISCHARGE: begin
            drive_d = (cnt_q + pwmp_pkg::CNT_W'(1)) < pwmp_pkg::SYNC_LEN;
            if (cnt_q >= dead_last) begin
               state_d = pwmp_pkg::PWMP_OSC_CHARGE;
               cnt_d = '0;
            end
         end
         default: begin
            state_d = pwmp_pkg::PWMP_OSC_CHARGE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= pwmp_pkg::PWMP_OSC_CHARGE;
         cnt_q <= '0;
         start_q <= 1'b0;
         drive_q <= 1'b0;
         line_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         start_q <= start_d;
         drive_q <= drive_d;
         line_q <= sync_line;
      end
   end

   assign osc.cycle_start = start_q;
   assign osc.dead = (state_q == pwmp_pkg::PWMP_OSC_DISCHARGE);
   assign osc.sync_drive = drive_q;
endmodule

// ===== verilog/pwmp_pkg.sv
// constants, state codes and carrier types of the pulse processing logic
package pwmp_pkg;

   // clock and oscillator timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int OSC_PERIOD_NS = 30000;
   localparam int OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DEAD_PCT_MIN = 3;
   localparam int CHG_DIS_RATIO = 29;
   localparam int DEAD_CYC_RATIO = (OSC_CYC + CHG_DIS_RATIO) / (CHG_DIS_RATIO + 1);
   localparam int DEAD_CYC_PCT = (OSC_CYC * DEAD_PCT_MIN + 99) / 100;
   localparam int DEAD_CYC = (DEAD_CYC_RATIO > DEAD_CYC_PCT) ? DEAD_CYC_RATIO : DEAD_CYC_PCT;
   localparam int CHARGE_CYC = OSC_CYC - DEAD_CYC;
   localparam int SYNC_PULSE_NS = 200;
   localparam int SYNC_CYC = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // widths
   localparam int CNT_W = 16;
   localparam int DEAD_EXT_W = 8;
   localparam int SYNC_STAGES = 3;

   localparam logic [CNT_W-1:0] CHARGE_LAST = CNT_W'(CHARGE_CYC - 1);
   localparam logic [CNT_W-1:0] DEAD_BASE = CNT_W'(DEAD_CYC);
   localparam logic [CNT_W-1:0] SYNC_LEN = CNT_W'(SYNC_CYC);

   // oscillator phases
   typedef enum logic [1:0] {
      PWMP_OSC_CHARGE = 2'b01,
      PWMP_OSC_DISCHARGE = 2'b10
   } pwmp_osc_e;

   // pin inputs after synchronisation
   typedef struct packed {
      logic pwm_cmp;
      logic cur_ok;
      logic shutdown_n;
      logic ref_ok;
      logic ss_reset_ext_n;
      logic sync_line;
      logic [DEAD_EXT_W-1:0] dead_ext;
   } pwmp_in_s;

   localparam int IN_W = $bits(pwmp_in_s);
   localparam logic [IN_W-1:0] IN_RESET = 14'h0000;

   // oscillator results
   typedef struct packed {
      logic cycle_start;
      logic dead;
      logic sync_drive;
   } pwmp_osc_s;

   // driver pair
   typedef struct packed {
      logic drive_a;
      logic drive_b;
   } pwmp_drv_s;

   localparam logic [1:0] DRV_RESET = 2'h0;

endpackage

// ===== verilog/pwmp_pulse_logic.sv
// pulse processing logic: gating, metering, double pulse suppression, lockout
`timescale 1ns/1ps
module pwmp_pulse_logic (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pwm_cmp,
   input wire logic cur_ok,
   input wire logic shutdown_n,
   input wire logic ref_ok,
   input wire logic ss_reset_ext_n,
   input wire logic [pwmp_pkg::DEAD_EXT_W-1:0] dead_ext,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n,
   output logic drive_a,
   output logic drive_b,
   output logic ss_reset_n,
   output logic lockout,
   output logic toggle_sel,
   output logic cycle_start
);
   pwmp_pkg::pwmp_in_s pin_raw;
   pwmp_pkg::pwmp_in_s pin_s;
   pwmp_pkg::pwmp_osc_s osc;

   logic gated;
   logic metered;
   logic deliver;
   logic armed_q;
   logic armed_d;
   logic pass_q;
   logic pass_d;
   logic mem_set_q;
   logic mem_set_d;
   logic tog_q;
   logic tog_d;
   logic lock_q;
   logic lock_d;
   logic ss_n_q;
   logic ss_n_d;
   pwmp_pkg::pwmp_drv_s drv_q;
   pwmp_pkg::pwmp_drv_s drv_d;

   // input synchronisation
   always_comb begin
      pin_raw.pwm_cmp = pwm_cmp;
      pin_raw.cur_ok = cur_ok;
      pin_raw.shutdown_n = shutdown_n;
      pin_raw.ref_ok = ref_ok;
      pin_raw.ss_reset_ext_n = ss_reset_ext_n;
      pin_raw.sync_line = sync_in;
      pin_raw.dead_ext = dead_ext;
   end

   pwmp_in_sync #(
      .W(pwmp_pkg::IN_W),
      .RST(pwmp_pkg::IN_RESET)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(pin_raw),
      .sync(pin_s)
   );

   // cycle timer
   pwmp_osc u_osc (
      .clk(clk),
      .reset_n(reset_n),
      .sync_line(pin_s.sync_line),
      .dead_ext(pin_s.dead_ext),
      .osc(osc)
   );

   // input gating and metering
   assign gated = pin_s.pwm_cmp & pin_s.cur_ok & pin_s.shutdown_n;
   assign metered = armed_q & gated & ~osc.dead;
   assign deliver = metered & ~lock_q;

   always_comb begin
      armed_d = armed_q;
      pass_d = deliver;
      if (osc.cycle_start) begin
         armed_d = 1'b1;
      end else if (pass_q && !deliver) begin
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_q <= 1'b0;
         pass_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         pass_q <= pass_d;
      end
   end

   // memory and toggle flip-flops
   always_comb begin
      mem_set_d = mem_set_q;
      tog_d = tog_q;
      if (osc.cycle_start) begin
         if (!mem_set_q) begin
            tog_d = ~tog_q;
         end
         mem_set_d = 1'b1;
      end
      if (deliver) begin
         mem_set_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_set_q <= 1'b1;
         tog_q <= 1'b0;
      end else begin
         mem_set_q <= mem_set_d;
         tog_q <= tog_d;
      end
   end

   // lockout and soft-start reset
   always_comb begin
      lock_d = ~pin_s.ref_ok;
      ss_n_d = pin_s.ss_reset_ext_n & ~lock_d;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_q <= 1'b1;
         ss_n_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         ss_n_q <= ss_n_d;
      end
   end

   // output drivers
   always_comb begin
      drv_d.drive_a = deliver & ~tog_q;
      drv_d.drive_b = deliver & tog_q;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drv_q <= pwmp_pkg::DRV_RESET;
      end else begin
         drv_q <= drv_d;
      end
   end

   assign drive_a = drv_q.drive_a;
   assign drive_b = drv_q.drive_b;
   assign ss_reset_n = ss_n_q;
   assign lockout = lock_q;
   assign toggle_sel = tog_q;
   assign cycle_start = osc.cycle_start;
   assign sync_out = osc.sync_drive;
   assign sync_oe_n = ~osc.sync_drive;
endmodule
